// >>> icsp_regs.vh
// Constants for the two-wire control slave port
`ifndef ICSP_REGS_VH
`define ICSP_REGS_VH
`define ICSP_ADDR_UPPER    5'h13
`define ICSP_BIT_CNT_LAST  3'h7
`define ICSP_BIT_CNT_INIT  3'h0
`define ICSP_PTR_RESET     8'h00
`define ICSP_BYTE_RESET    8'h00
`define ICSP_ST_IDLE       3'h0
`define ICSP_ST_ADDR       3'h1
`define ICSP_ST_ACK_ADDR   3'h2
`define ICSP_ST_WRITE      3'h3
`define ICSP_ST_ACK_WRITE  3'h4
`define ICSP_ST_READ       3'h5
`define ICSP_ST_ACK_READ   3'h6
`endif

// >>> icsp_slave.v
// Two-wire control slave port: address match, pointer and sequential register access
`include "icsp_regs.vh"
`default_nettype none
module icsp_slave (
    // Clock and reset
    input  wire       sys_clk_in,
    input  wire       rst_in,
    // Mode and straps
    input  wire       select_pin_in,
    input  wire       shutdown_in,
    input  wire       address_strap_bit0_pin_in,
    input  wire       address_strap_bit1_pin_in,
    // Bus lines
    input  wire       serial_clock_pin_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_out,
    output reg        scl_out,
    output reg        scl_oe_out,
    // Register file side
    input  wire [7:0] reg_rdata_in,
    output reg  [7:0] reg_addr_out,
    output reg  [7:0] reg_wdata_out,
    output reg        reg_wr_out,
    output reg        reg_rd_out
);
    reg  [1:0] scl_sync_reg;
    reg  [1:0] sda_sync_reg;
    reg  [1:0] sel_sync_reg;
    reg  [1:0] sd_sync_reg;
    reg  [1:0] a0_sync_reg;
    reg  [1:0] a1_sync_reg;
    reg        scl_d_reg;
    reg        sda_d_reg;
    reg  [2:0] state_reg;
    reg  [2:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] ptr_reg;
    reg  [7:0] tx_reg;
    reg        ptr_loaded_reg;
    reg        is_read_reg;
    reg        active_reg;
    wire       scl_s;
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire       enabled;
    wire [7:0] rx_byte;

    assign scl_s     = scl_sync_reg[1];
    assign sda_s     = sda_sync_reg[1];
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign enabled   = ~sel_sync_reg[1] & ~sd_sync_reg[1];
    assign rx_byte   = {shift_reg[6:0], sda_s};

    // Input synchronisers
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            sel_sync_reg <= 2'h3;
            sd_sync_reg  <= 2'h3;
            a0_sync_reg  <= 2'h0;
            a1_sync_reg  <= 2'h0;
            scl_d_reg    <= 1'h1;
            sda_d_reg    <= 1'h1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], serial_clock_pin_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            sel_sync_reg <= {sel_sync_reg[0], select_pin_in};
            sd_sync_reg  <= {sd_sync_reg[0], shutdown_in};
            a0_sync_reg  <= {a0_sync_reg[0], address_strap_bit0_pin_in};
            a1_sync_reg  <= {a1_sync_reg[0], address_strap_bit1_pin_in};
            scl_d_reg    <= scl_s;
            sda_d_reg    <= sda_s;
        end
    end

    // Protocol engine
    always @(posedge sys_clk_in)
    begin
        reg_wr_out <= 1'h0;
        reg_rd_out <= 1'h0;
        scl_out    <= 1'h0;
        scl_oe_out <= 1'h0;
        sda_out    <= 1'h0;
        if (rst_in || !enabled)
        begin
            state_reg      <= `ICSP_ST_IDLE;
            bit_cnt_reg    <= `ICSP_BIT_CNT_INIT;
            shift_reg      <= `ICSP_BYTE_RESET;
            ptr_reg        <= `ICSP_PTR_RESET;
            tx_reg         <= `ICSP_BYTE_RESET;
            ptr_loaded_reg <= 1'h0;
            is_read_reg    <= 1'h0;
            active_reg     <= 1'h0;
            sda_oe_out     <= 1'h0;
            reg_addr_out   <= `ICSP_PTR_RESET;
            reg_wdata_out  <= `ICSP_BYTE_RESET;
        end
        else if (start_det)
        begin
            state_reg   <= `ICSP_ST_ADDR;
            bit_cnt_reg <= `ICSP_BIT_CNT_INIT;
            sda_oe_out  <= 1'h0;
            active_reg  <= 1'h0;
        end
        else if (stop_det)
        begin
            state_reg  <= `ICSP_ST_IDLE;
            sda_oe_out <= 1'h0;
            active_reg <= 1'h0;
        end
        else
        begin
            case (state_reg)
                `ICSP_ST_ADDR, `ICSP_ST_WRITE:
                begin
                    if (scl_rise)
                    begin
                        shift_reg   <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == `ICSP_BIT_CNT_INIT && active_reg)
                    begin
                        // Full byte received; value sits in shift_reg
                        active_reg <= 1'h0;
                        if (state_reg == `ICSP_ST_ADDR)
                        begin
                            if (shift_reg[7:1] == {`ICSP_ADDR_UPPER, a1_sync_reg[1], a0_sync_reg[1]})
                            begin
                                is_read_reg <= shift_reg[0];
                                sda_oe_out  <= 1'h1;
                                state_reg   <= `ICSP_ST_ACK_ADDR;
                                if (shift_reg[0])
                                begin
                                    tx_reg     <= reg_rdata_in;
                                    reg_rd_out <= 1'h1;
                                end
                            end
                            else
                                state_reg <= `ICSP_ST_IDLE;
                        end
                        else
                        begin
                            sda_oe_out <= 1'h1;
                            state_reg  <= `ICSP_ST_ACK_WRITE;
                            if (!ptr_loaded_reg)
                            begin
                                ptr_reg        <= shift_reg;
                                reg_addr_out   <= shift_reg;
                                ptr_loaded_reg <= 1'h1;
                            end
                            else
                            begin
                                reg_wdata_out <= shift_reg;
                                reg_addr_out  <= ptr_reg;
                                reg_wr_out    <= 1'h1;
                                ptr_reg       <= ptr_reg + 8'h01;
                            end
                        end
                    end
                    else if (scl_rise == 1'h0 && scl_s && bit_cnt_reg == `ICSP_BIT_CNT_LAST)
                        active_reg <= 1'h1;
                end
                `ICSP_ST_ACK_ADDR, `ICSP_ST_ACK_WRITE:
                begin
                    if (scl_fall) // ack ends after its clock: released, or first read bit driven
                    begin
                        bit_cnt_reg <= `ICSP_BIT_CNT_INIT;
                        if (state_reg == `ICSP_ST_ACK_ADDR && is_read_reg)
                        begin
                            state_reg  <= `ICSP_ST_READ;
                            sda_oe_out <= ~tx_reg[7];
                            tx_reg     <= {tx_reg[6:0], 1'h0};
                            ptr_reg    <= ptr_reg + 8'h01;
                        end
                        else
                        begin
                            state_reg  <= `ICSP_ST_WRITE;
                            sda_oe_out <= 1'h0;
                            if (state_reg == `ICSP_ST_ACK_ADDR)
                                ptr_loaded_reg <= 1'h0;
                        end
                    end
                end
                `ICSP_ST_READ:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == `ICSP_BIT_CNT_LAST)
                        begin
                            sda_oe_out <= 1'h0;
                            state_reg  <= `ICSP_ST_ACK_READ;
                        end
                        else
                        begin
                            sda_oe_out <= ~tx_reg[7];
                            tx_reg     <= {tx_reg[6:0], 1'h0};
                        end
                    end
                end
                `ICSP_ST_ACK_READ:
                begin
                    if (scl_rise)
                    begin
                        if (sda_s)
                            state_reg <= `ICSP_ST_IDLE;
                        else
                        begin
                            reg_addr_out <= ptr_reg;
                            reg_rd_out   <= 1'h1;
                            active_reg   <= 1'h1;
                        end
                    end
                    else if (scl_fall && active_reg)
                    begin
                        active_reg  <= 1'h0;
                        state_reg   <= `ICSP_ST_READ;
                        bit_cnt_reg <= `ICSP_BIT_CNT_INIT;
                        sda_oe_out  <= ~reg_rdata_in[7];
                        tx_reg      <= {reg_rdata_in[6:0], 1'h0};
                        ptr_reg     <= ptr_reg + 8'h01;
                    end
                end
                default:
                begin
                    sda_oe_out <= 1'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> icsp_checker.sv
// Checker of the two-wire control slave port pins
`default_nettype none
module icsp_checker (
    // Clock, reset and mode
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic       select_pin_in,
    input wire logic       shutdown_in,
    // Bus lines
    input wire logic       serial_clock_pin_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       scl_oe_out,
    // Register file side
    input wire logic [7:0] reg_addr_out,
    input wire logic       reg_wr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] next_addr_reg;
    logic       wr_seen_reg;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // Next write address within one transfer
    always @(posedge sys_clk_in)
    begin
        if (rst_in || (serial_clock_pin_in && $fell(sda_in)))
            wr_seen_reg <= 1'b0;
        else if (reg_wr_out)
            wr_seen_reg <= 1'b1;
        if (reg_wr_out)
            next_addr_reg <= reg_addr_out + 8'h01;
    end
    AST_SDA_PULL_ONLY: assert property (sda_oe_out |-> sda_out == 1'b0)
        else $error("SDA driven high");
    AST_SCL_UNDRIVEN: assert property (!scl_oe_out)
        else $error("SCL driven");
    AST_SHUTDOWN_FREE: assert property (shutdown_in [*5] |-> !sda_oe_out)
        else $error("SDA held in shutdown");
    AST_SELECT_FREE: assert property (select_pin_in [*5] |-> !sda_oe_out)
        else $error("SDA held in other mode");
    AST_SDA_LOW_PHASE: assert property (($changed(sda_oe_out) && !shutdown_in && !select_pin_in)
        |-> !serial_clock_pin_in) else $error("SDA changed with clock high");
    AST_ACK_WHOLE: assert property ($rose(sda_oe_out) |=> sda_oe_out [*6])
        else $error("SDA low too short");
    AST_WR_WITH_ACK: assert property (reg_wr_out |-> ##[0:2] sda_oe_out)
        else $error("Write without ack");
    AST_WR_SINGLE: assert property (reg_wr_out |=> !reg_wr_out)
        else $error("Write pulse too long");
    AST_WR_STEP: assert property (reg_wr_out && wr_seen_reg |-> reg_addr_out == next_addr_reg)
        else $error("Write address did not step");
endmodule
`default_nettype wire

// >>> icsp_master_model.sv
// Bus master model for the two-wire control port
`default_nettype none
module icsp_master_model (
    // Bus lines
    output logic      scl_out,
    output logic      sda_out,
    input  wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // One bit: change in low phase, sample mid high
    task automatic slot(input logic b, output logic s);
        #100 sda_out = b;
        #150 scl_out = 1'b1;
        #75 s = sda_in;
        #75 scl_out = 1'b0;
    endtask
    // Start when b is 1, stop when b is 0
    task automatic cond(input logic b);
        #100 sda_out = b;
        #150 scl_out = 1'b1;
        #75 sda_out = ~b;
        #75 scl_out = ~b;
    endtask
    // Byte out and in, then the answer bit
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic s9);
        for (int i = 7; i >= 0; i--)
            slot(d[i], q[i]);
        slot(nine, s9);
    endtask
endmodule
`default_nettype wire

// >>> i2c_control_slave_port_test.sv
// Testbench for the two-wire control slave port
`default_nettype none
module i2c_control_slave_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk;
    logic       rst;
    logic       sel;
    logic       shut;
    logic [1:0] strap;
    logic [7:0] mem [256];
    wire        m_scl, m_sda, sda_oe, sda_o, scl_oe, scl_o, wr, rd;
    wire  [7:0] addr, wdata, rdata;
    wire        scl_bus;
    wire        sda_bus;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cycles = 0;
    int         n_rd = 0;
    logic [7:0] pat [3] = '{8'h81, 8'h5A, 8'h3C};
    // Register file behind the port
    assign rdata = mem[addr];
    always @(posedge sys_clk)
        if (wr)
            mem[addr] <= wdata;
    // Read fetch pulses seen on the register side
    always @(posedge sys_clk)
        if (rd)
            n_rd <= n_rd + 1;
    // Wired-AND bus lines with pull-ups
    assign scl_bus = m_scl & (scl_oe ? scl_o : 1'h1);
    assign sda_bus = m_sda & (sda_oe ? sda_o : 1'h1);
    icsp_slave dut_u (.sys_clk_in(sys_clk), .rst_in(rst), .select_pin_in(sel), .shutdown_in(shut),
        .address_strap_bit0_pin_in(strap[0]), .address_strap_bit1_pin_in(strap[1]),
        .serial_clock_pin_in(scl_bus), .sda_in(sda_bus),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .scl_out(scl_o), .scl_oe_out(scl_oe), .reg_rdata_in(rdata),
        .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
    icsp_master_model m_u (.scl_out(m_scl), .sda_out(m_sda), .sda_in(sda_bus));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Byte from master, ack compared with expectation
    task automatic wb(input logic [7:0] b, input logic exp, input string msg);
        logic [7:0] q;
        logic       s9;
        m_u.xfer(b, 1'b1, q, s9);
        check({7'h00, !s9}, {7'h00, exp}, msg);
    endtask
    task automatic t_write_read();
        logic [7:0] d;
        logic       s9;
        int         rd_base;
        rd_base = n_rd;
        m_u.cond(1'b1);
        wb(8'h98, 1'b1, "write address ack");
        wb(8'h10, 1'b1, "pointer ack");
        for (int i = 0; i < 3; i++)
            wb(pat[i], 1'b1, "data ack");
        m_u.cond(1'b0);
        for (int i = 0; i < 3; i++)
            check(mem[8'h10 + i], pat[i], "register written");
        m_u.cond(1'b1);
        wb(8'h98, 1'b1, "write address ack");
        wb(8'h10, 1'b1, "pointer ack");
        m_u.cond(1'b1);
        wb(8'h99, 1'b1, "read address ack");
        for (int i = 0; i < 3; i++)
        begin
            m_u.xfer(8'hFF, i == 2, d, s9);
            check(d, pat[i], "read data");
        end
        m_u.cond(1'b0);
        check(8'(n_rd - rd_base), 8'h03, "read fetch pulses");
        $display("Test write_read done");
    endtask
    task automatic t_release();
        for (int k = 0; k < 2; k++)
        begin
            tick(1);
            sel = (k == 1);
            shut = (k == 0);
            tick(4);
            m_u.cond(1'b1);
            wb(8'h98, 1'b0, "released lines");
            m_u.cond(1'b0);
            tick(1);
            sel = 1'b0;
            shut = 1'b0;
        end
        $display("Test release done");
    endtask
    task automatic t_straps();
        for (int s = 0; s < 4; s++)
        begin
            tick(1);
            strap = 2'(s);
            tick(4);
            m_u.cond(1'b1);
            wb({5'h13, 2'(s), 1'b0}, 1'b1, "strap address ack");
            m_u.cond(1'b0);
            m_u.cond(1'b1);
            wb({5'h13, 2'(s + 1), 1'b0}, 1'b0, "other address ignored");
            m_u.cond(1'b0);
        end
        $display("Test straps done");
    endtask
    initial
    begin
        rst = 1'b1;
        sel = 1'b0;
        shut = 1'b0;
        strap = 2'b00;
        tick(6);
        rst = 1'b0;
        tick(3);
        t_write_read();
        t_release();
        t_straps();
        print_verdict();
    end
endmodule
bind icsp_slave icsp_checker chk_u (
    .sys_clk_in          (sys_clk_in),
    .rst_in              (rst_in),
    .select_pin_in       (select_pin_in),
    .shutdown_in         (shutdown_in),
    .serial_clock_pin_in (serial_clock_pin_in),
    .sda_in              (sda_in),
    .sda_out             (sda_out),
    .sda_oe_out          (sda_oe_out),
    .scl_oe_out          (scl_oe_out),
    .reg_addr_out        (reg_addr_out),
    .reg_wr_out          (reg_wr_out)
);
`default_nettype wire
